// ---- include/ewim_pkg.sv ----
// Package: exception numbers, vector map, wake masks and priority layout
package ewim_pkg;
    // Exception numbers
    localparam logic [3:0] EXC_NONE = 4'h0;
    localparam logic [3:0] EXC_NMI = 4'h2;
    localparam logic [3:0] EXC_HARD = 4'h3;
    localparam logic [3:0] EXC_MEM = 4'h4;
    localparam logic [3:0] EXC_BUS = 4'h5;
    localparam logic [3:0] EXC_USAGE = 4'h6;
    localparam logic [3:0] EXC_SVC = 4'hb;
    localparam logic [3:0] EXC_DBG = 4'hc;
    localparam logic [3:0] EXC_PENDSRV = 4'he;
    localparam logic [3:0] EXC_TICK = 4'hf;
    // Number of peripheral positions handled here
    localparam int NUM_IRQ = 20;
    localparam int PRIO_W = 3;
    localparam logic [2:0] PRIO_RESET = 3'h0;
    // Positions that exist; 4, 7, 11, 12 are reserved
    localparam logic [19:0] IRQ_PRESENT = 20'hfe76f;
    // Positions allowed to wake from Mode 2 and Mode 3
    localparam logic [19:0] WAKE_DEEP_MASK = 20'h0076f;
    // Power modes
    localparam logic [1:0] MODE_FULL = 2'h0;
    localparam logic [1:0] MODE_1 = 2'h1;
    localparam logic [1:0] MODE_2 = 2'h2;
    localparam logic [1:0] MODE_3 = 2'h3;
    // Programmable system exception slots: mem, bus, usage, svc, dbg, pendable, tick
    localparam int NUM_SYS = 7;
endpackage

// ---- rtl/ewim_prio_store.sv ----
// Small memory holding the three-bit priority level of each programmable source
`timescale 1ns/1ns
module ewim_prio_store
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Write port
    input wire logic wr_en_i,
    input wire logic [4:0] wr_idx_i,
    input wire logic [2:0] wr_level_i,
    // Read: all levels registered
    output logic [(ewim_pkg::NUM_IRQ+ewim_pkg::NUM_SYS)*3-1:0] levels_o
);
    localparam int N = ewim_pkg::NUM_IRQ + ewim_pkg::NUM_SYS;
    logic [N*3-1:0] mem_r;
    logic [N*3-1:0] mem_nxt;

    always_comb
    begin
        mem_nxt = mem_r;
        if (wr_en_i && (int'(wr_idx_i) < N))
        begin
            mem_nxt[wr_idx_i*3 +: 3] = wr_level_i;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            mem_r <= {N{ewim_pkg::PRIO_RESET}};
        end
        else
        begin
            mem_r <= mem_nxt;
        end
    end

    assign levels_o = mem_r;
endmodule

// ---- rtl/ewim_core.sv ----
// Exception and peripheral interrupt front end with low power wake decision
`timescale 1ns/1ns
module ewim_core
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Fault causes from the core
    input wire logic invalid_access_i,
    input wire logic bus_err_i,
    input wire logic usage_err_i,
    input wire logic svc_exec_i,
    input wire logic dbg_event_i,
    input wire logic pendsrv_set_i,
    input wire logic tick_i,
    input wire logic [2:0] fault_handler_en_i,
    // Peripheral requests and enables
    input wire logic [19:0] irq_i,
    input wire logic [19:0] irq_en_i,
    // Priority programming (index 0-19 peripherals, 20-26 system)
    input wire logic prio_wr_i,
    input wire logic [4:0] prio_idx_i,
    input wire logic [2:0] prio_level_i,
    // Core handshake
    input wire logic take_i,
    input wire logic exit_i,
    input wire logic [1:0] sleep_mode_i,
    input wire logic sleep_req_i,
    // Results
    output logic exc_valid_o,
    output logic [3:0] exc_num_o,
    output logic irq_valid_o,
    output logic [4:0] irq_pos_o,
    output logic nmi_req_o,
    output logic wake_o,
    output logic [1:0] power_mode_o,
    output logic [19:0] irq_pending_o
);
    localparam int N = ewim_pkg::NUM_IRQ;
    localparam int NS = ewim_pkg::NUM_SYS;

    // ****************************************************
    // Priority storage
    // ****************************************************
    logic [(N+NS)*3-1:0] levels;

    ewim_prio_store u_prio
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wr_en_i(prio_wr_i),
        .wr_idx_i(prio_idx_i),
        .wr_level_i(prio_level_i),
        .levels_o(levels)
    );

    function automatic logic [2:0] lvl(input logic [(N+NS)*3-1:0] l, input int i);
        lvl = l[i*3 +: 3];
    endfunction

    // ****************************************************
    // Pending state
    // ****************************************************
    typedef enum logic [2:0]
    {
        EWIM_RUN = 3'b001,
        EWIM_SLEEP = 3'b010,
        EWIM_WAKE = 3'b100
    } ewim_pwr_e;

    logic [N-1:0] pend_r, pend_nxt;
    logic [NS-1:0] spend_r, spend_nxt;
    logic hard_r, hard_nxt;
    logic active_r, active_nxt;
    logic [2:0] act_lvl_r, act_lvl_nxt;
    logic [4:0] pos_r, pos_nxt;
    logic [3:0] num_r, num_nxt;
    logic irqv_r, irqv_nxt, excv_r, excv_nxt;
    ewim_pwr_e st_r, st_nxt;
    logic [1:0] mode_r, mode_nxt;
    logic wake_r, wake_nxt;

    logic [N-1:0] req;
    logic [NS-1:0] sreq;
    logic [2:0] fault_raw;
    logic esc;
    assign req = irq_i & irq_en_i & ewim_pkg::IRQ_PRESENT;
    assign fault_raw = {usage_err_i, bus_err_i, invalid_access_i};
    assign esc = |(fault_raw & ~fault_handler_en_i);
    assign sreq = {tick_i, pendsrv_set_i, dbg_event_i, svc_exec_i,
                   fault_raw & fault_handler_en_i};

    // Lowest level value wins; strict less keeps lower position on ties
    logic [4:0] best_pos;
    logic [2:0] best_lvl;
    logic best_any;
    logic [2:0] sbest_idx;
    logic [2:0] sbest_lvl;
    logic sbest_any;
    logic [N-1:0] wake_ok;

    always_comb
    begin
        best_pos = 5'h0;
        best_lvl = 3'h7;
        best_any = 1'b0;
        for (int i = 0; i < N; i++)
        begin
            if (pend_r[i] && (!best_any || lvl(levels, i) < best_lvl))
            begin
                best_any = 1'b1;
                best_lvl = lvl(levels, i);
                best_pos = 5'(i);
            end
        end
        sbest_idx = 3'h0;
        sbest_lvl = 3'h7;
        sbest_any = 1'b0;
        for (int j = 0; j < NS; j++)
        begin
            if (spend_r[j] && (!sbest_any || lvl(levels, N + j) < sbest_lvl))
            begin
                sbest_any = 1'b1;
                sbest_lvl = lvl(levels, N + j);
                sbest_idx = 3'(j);
            end
        end
    end

    function automatic logic [3:0] sys_num(input logic [2:0] idx);
        case (idx)
            3'h0: sys_num = ewim_pkg::EXC_MEM;
            3'h1: sys_num = ewim_pkg::EXC_BUS;
            3'h2: sys_num = ewim_pkg::EXC_USAGE;
            3'h3: sys_num = ewim_pkg::EXC_SVC;
            3'h4: sys_num = ewim_pkg::EXC_DBG;
            3'h5: sys_num = ewim_pkg::EXC_PENDSRV;
            default: sys_num = ewim_pkg::EXC_TICK;
        endcase
    endfunction

    // ****************************************************
    // Wake qualification
    // ****************************************************
    genvar g;
    generate
        for (g = 0; g < N; g++)
        begin : g_wake
            logic mode_ok;
            logic prio_ok;
            assign mode_ok = (mode_r == ewim_pkg::MODE_1) ? ewim_pkg::IRQ_PRESENT[g]
                           : ewim_pkg::WAKE_DEEP_MASK[g];
            assign prio_ok = !active_r || (lvl(levels, g) < act_lvl_r);
            assign wake_ok[g] = pend_r[g] && mode_ok && prio_ok;
        end
    endgenerate

    // ****************************************************
    // Next-state logic
    // ****************************************************
    always_comb
    begin
        pend_nxt = pend_r | req;
        spend_nxt = spend_r | sreq;
        hard_nxt = hard_r | esc;
        active_nxt = active_r;
        act_lvl_nxt = act_lvl_r;
        pos_nxt = pos_r;
        num_nxt = num_r;
        irqv_nxt = 1'b0;
        excv_nxt = 1'b0;
        st_nxt = st_r;
        mode_nxt = mode_r;
        wake_nxt = 1'b0;
        if (exit_i)
        begin
            active_nxt = 1'b0;
        end
        // Hard fault outranks every programmable source
        if (hard_r)
        begin
            excv_nxt = 1'b1;
            num_nxt = ewim_pkg::EXC_HARD;
            if (take_i)
            begin
                hard_nxt = esc;
            end
        end
        else if (sbest_any && (!best_any || sbest_lvl <= best_lvl))
        begin
            excv_nxt = 1'b1;
            num_nxt = sys_num(sbest_idx);
            if (take_i)
            begin
                spend_nxt[sbest_idx] = sreq[sbest_idx];
                active_nxt = 1'b1;
                act_lvl_nxt = sbest_lvl;
            end
        end
        else if (best_any && st_r == EWIM_RUN)
        begin
            irqv_nxt = 1'b1;
            pos_nxt = best_pos;
            if (take_i)
            begin
                // A new request in the same cycle keeps the flag set
                pend_nxt[best_pos] = req[best_pos];
                active_nxt = 1'b1;
                act_lvl_nxt = best_lvl;
            end
        end
        case (st_r)
            EWIM_RUN:
            begin
                if (sleep_req_i && sleep_mode_i != ewim_pkg::MODE_FULL)
                begin
                    st_nxt = EWIM_SLEEP;
                    mode_nxt = sleep_mode_i;
                end
            end
            EWIM_SLEEP:
            begin
                if (|wake_ok)
                begin
                    st_nxt = EWIM_WAKE;
                end
            end
            EWIM_WAKE:
            begin
                wake_nxt = 1'b1;
                mode_nxt = ewim_pkg::MODE_FULL;
                st_nxt = EWIM_RUN;
            end
            default:
            begin
                st_nxt = EWIM_RUN;
                mode_nxt = ewim_pkg::MODE_FULL;
            end
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pend_r <= '0;
            spend_r <= '0;
            hard_r <= 1'b0;
            active_r <= 1'b0;
            act_lvl_r <= ewim_pkg::PRIO_RESET;
            pos_r <= 5'h0;
            num_r <= ewim_pkg::EXC_NONE;
            irqv_r <= 1'b0;
            excv_r <= 1'b0;
            st_r <= EWIM_RUN;
            mode_r <= ewim_pkg::MODE_FULL;
            wake_r <= 1'b0;
        end
        else
        begin
            pend_r <= pend_nxt;
            spend_r <= spend_nxt;
            hard_r <= hard_nxt;
            active_r <= active_nxt;
            act_lvl_r <= act_lvl_nxt;
            pos_r <= pos_nxt;
            num_r <= num_nxt;
            irqv_r <= irqv_nxt;
            excv_r <= excv_nxt;
            st_r <= st_nxt;
            mode_r <= mode_nxt;
            wake_r <= wake_nxt;
        end
    end

    // ****************************************************
    // Outputs
    // ****************************************************
    assign nmi_req_o = 1'b0;
    assign exc_valid_o = excv_r;
    assign exc_num_o = num_r;
    assign irq_valid_o = irqv_r;
    assign irq_pos_o = pos_r;
    assign wake_o = wake_r;
    assign power_mode_o = mode_r;
    assign irq_pending_o = pend_r;
endmodule

// ---- bench/ewim_core_sva.sv ----
// Checker: port-level properties of the exception and wake front end
`timescale 1ns/1ns
module ewim_core_sva
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Causes
    input wire logic invalid_access_i,
    input wire logic [2:0] fault_handler_en_i,
    input wire logic [19:0] irq_i,
    input wire logic [19:0] irq_en_i,
    input wire logic sleep_req_i,
    input wire logic [1:0] sleep_mode_i,
    // Results
    input wire logic exc_valid_o,
    input wire logic [3:0] exc_num_o,
    input wire logic irq_valid_o,
    input wire logic [4:0] irq_pos_o,
    input wire logic nmi_req_o,
    input wire logic wake_o,
    input wire logic [1:0] power_mode_o,
    input wire logic [19:0] irq_pending_o
);
    logic [19:0] req_w;
    logic [19:0] pend_q;
    assign req_w = irq_i & irq_en_i & ewim_pkg::IRQ_PRESENT;
    always_ff @(posedge clk_i)
    begin
        pend_q <= irq_pending_o;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_nmi_idle: assert property (!nmi_req_o) else $error("nmi request raised");
    a_reserved_idle: assert property ((irq_pending_o & ~ewim_pkg::IRQ_PRESENT) == 20'h0)
        else $error("reserved position pending");
    a_pend_cause: assert property ((irq_pending_o & ~pend_q & ~$past(req_w)) == 20'h0)
        else $error("pending without request");
    a_pend_set: assert property (req_w != 20'h0 |=> (irq_pending_o & $past(req_w)) == $past(req_w))
        else $error("request not pended");
    a_hard_first: assert property (invalid_access_i && !fault_handler_en_i[0] |-> ##2
        exc_valid_o && exc_num_o == ewim_pkg::EXC_HARD) else $error("no escalation");
    a_quiet_asleep: assert property (power_mode_o != 2'h0 && $past(power_mode_o) != 2'h0 |-> !irq_valid_o)
        else $error("irq presented asleep");
    a_wake_full: assert property (wake_o |-> power_mode_o == ewim_pkg::MODE_FULL)
        else $error("wake not in full mode");
    a_wake_pulse: assert property (wake_o |=> !wake_o) else $error("wake too long");
    a_valid_pend: assert property (irq_valid_o |-> pend_q[irq_pos_o])
        else $error("irq presented not pending");
    a_sleep_entry: assert property (sleep_req_i && sleep_mode_i != 2'h0 && power_mode_o == 2'h0
        |=> power_mode_o == $past(sleep_mode_i)) else $error("sleep not entered");
    c_wake: cover property (wake_o);
    c_hard: cover property (exc_valid_o && exc_num_o == ewim_pkg::EXC_HARD);
    c_irq: cover property (irq_valid_o && power_mode_o == ewim_pkg::MODE_FULL);
endmodule
bind ewim_core ewim_core_sva u_ewim_core_sva (.clk_i, .rst_i, .invalid_access_i, .fault_handler_en_i, .irq_i,
    .irq_en_i, .sleep_req_i, .sleep_mode_i, .exc_valid_o, .exc_num_o, .irq_valid_o, .irq_pos_o, .nmi_req_o,
    .wake_o, .power_mode_o, .irq_pending_o);

// ---- bench/ewim_core_model.sv ----
// Core-side model: accepts presented requests, promptly or with a longer gap
`timescale 1ns/1ns
module ewim_core_model
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Answer mode
    input wire logic auto_i,
    input wire logic slow_i,
    // Presented requests
    input wire logic irq_valid_i,
    input wire logic exc_valid_i,
    // Accept pulse
    output logic take_o
);
    logic [1:0] gap_r;
    logic [1:0] gap_nxt;
    logic take_nxt;
    // Valid lags a take by a cycle; the gap stops a second take of the same request
    always_comb
    begin
        take_nxt = 1'b0;
        gap_nxt = (gap_r != 2'h0) ? gap_r - 2'h1 : gap_r;
        if (auto_i && (irq_valid_i || exc_valid_i) && gap_r == 2'h0 && !take_o)
        begin
            take_nxt = 1'b1;
            gap_nxt = slow_i ? 2'h3 : 2'h2;
        end
    end
    always_ff @(posedge clk_i)
    begin
        gap_r <= rst_i ? 2'h0 : gap_nxt;
        take_o <= rst_i ? 1'b0 : take_nxt;
    end
endmodule

// ---- bench/exception_wake_interrupt_map_bench.sv ----
// Bench: self-checking run of the exception, vector and wake front end
`timescale 1ns/1ns
module exception_wake_interrupt_map_bench;
    logic clk_i, rst_i, take_i, exit_i, prio_wr_i, sleep_req_i, auto, slow, w;
    logic invalid_access_i, bus_err_i, usage_err_i, svc_exec_i, dbg_event_i, pendsrv_set_i, tick_i;
    logic exc_valid_o, irq_valid_o, nmi_req_o, wake_o;
    logic [6:0] cause;
    logic [2:0] fault_handler_en_i, prio_level_i;
    logic [19:0] irq_i, irq_en_i, irq_pending_o, r;
    logic [4:0] prio_idx_i, irq_pos_o, p;
    logic [1:0] sleep_mode_i, power_mode_o;
    logic [3:0] exc_num_o;
    int n_fail, checks, k;
    assign {tick_i, pendsrv_set_i, dbg_event_i, svc_exec_i, usage_err_i, bus_err_i, invalid_access_i} = cause;
    ewim_core u_ewim_core (.clk_i, .rst_i, .invalid_access_i, .bus_err_i, .usage_err_i, .svc_exec_i,
        .dbg_event_i, .pendsrv_set_i, .tick_i, .fault_handler_en_i, .irq_i, .irq_en_i, .prio_wr_i, .prio_idx_i,
        .prio_level_i, .take_i, .exit_i, .sleep_mode_i, .sleep_req_i, .exc_valid_o, .exc_num_o, .irq_valid_o,
        .irq_pos_o, .nmi_req_o, .wake_o, .power_mode_o, .irq_pending_o);
    ewim_core_model u_ewim_core_model (.clk_i, .rst_i, .auto_i(auto), .slow_i(slow),
        .irq_valid_i(irq_valid_o), .exc_valid_i(exc_valid_o), .take_o(take_i));
    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("BAD t=%0t %s seen %0h exp %0h", $time, what, seen, exp);
        end
    endtask
    task report_and_stop;
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task do_reset;
        @(posedge clk_i);
        rst_i <= 1'b1;
        irq_i <= 20'h0;
        irq_en_i <= 20'hfffff;
        auto <= 1'b0;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
    endtask
    task prio(input logic [4:0] idx, input logic [2:0] lv);
        @(posedge clk_i);
        prio_wr_i <= 1'b1;
        prio_idx_i <= idx;
        prio_level_i <= lv;
        @(posedge clk_i);
        prio_wr_i <= 1'b0;
    endtask
    task sleep(input logic [1:0] m);
        @(posedge clk_i);
        sleep_mode_i <= m;
        sleep_req_i <= 1'b1;
        @(posedge clk_i);
        sleep_req_i <= 1'b0;
        @(posedge clk_i);
    endtask
    // Bounded look for the wake pulse; a sleeping block must never hang the run
    task wait_wake(output logic seen);
        seen = 1'b0;
        repeat (8)
        begin
            @(posedge clk_i);
            #1;
            if (wake_o === 1'b1)
            begin
                seen = 1'b1;
                chk(power_mode_o, ewim_pkg::MODE_FULL, "mode after wake");
            end
        end
    endtask
    function automatic logic [4:0] lowest(input logic [19:0] m);
        lowest = 5'h0;
        for (int i = 19; i >= 0; i--)
            if (m[i])
                lowest = i[4:0];
    endfunction
    function automatic logic [3:0] exp_exc(input int c, input logic en);
        logic [3:0] t [7];
        t = '{ewim_pkg::EXC_MEM, ewim_pkg::EXC_BUS, ewim_pkg::EXC_USAGE, ewim_pkg::EXC_SVC, ewim_pkg::EXC_DBG,
            ewim_pkg::EXC_PENDSRV, ewim_pkg::EXC_TICK};
        exp_exc = (c < 3 && !en) ? ewim_pkg::EXC_HARD : t[c];
    endfunction
    initial
    begin
        rst_i = 1'b1;
        {cause, exit_i, prio_wr_i, sleep_req_i, auto, slow} = '0;
        {fault_handler_en_i, prio_level_i, prio_idx_i, sleep_mode_i, irq_i} = '0;
        irq_en_i = 20'hfffff;
        void'($urandom(32'h80f15836));
        do_reset;
        @(posedge clk_i);
        #1;
        chk({nmi_req_o, exc_valid_o, irq_valid_o, wake_o, power_mode_o, irq_pending_o}, 0, "reset");
        for (k = 0; k < 14; k++)
        begin
            do_reset;
            fault_handler_en_i <= (k < 7) ? 3'h0 : 3'h7;
            cause <= 7'h1 << (k % 7);
            @(posedge clk_i);
            cause <= 7'h0;
            @(posedge clk_i);
            #1;
            chk(exc_valid_o, 1, "exc valid");
            chk(exc_num_o, exp_exc(k % 7, k >= 7), "exc number");
        end
        $display("test exceptions done");
        for (k = 0; k < 10; k++)
        begin
            do_reset;
            r = 20'($urandom) & ewim_pkg::IRQ_PRESENT;
            r[k] = 1'b1;
            irq_i <= r;
            // Random enables: a disabled line must never pend
            irq_en_i <= 20'($urandom) | (20'h1 << k);
            repeat (2) @(posedge clk_i);
            #1;
            r = r & ewim_pkg::IRQ_PRESENT & irq_en_i;
            chk(irq_pending_o, r, "pending");
            chk(irq_pos_o, lowest(r), "tie order");
            p = lowest(r);
            prio(p, 3'($urandom_range(7, 1)));
            r[p] = 1'b0;
            repeat (2) @(posedge clk_i);
            #1;
            chk(irq_pos_o, (r == 20'h0) ? p : lowest(r), "level order");
        end
        $display("test order done");
        for (k = 0; k < 60; k++)
        begin
            do_reset;
            sleep(2'(k / 20 + 1));
            irq_i[k % 20] <= 1'b1;
            wait_wake(w);
            r = (k < 20) ? ewim_pkg::IRQ_PRESENT : ewim_pkg::WAKE_DEEP_MASK;
            chk(w, r[k % 20], "wake");
        end
        $display("test wake done");
        do_reset;
        prio(5'd1, 3'h3);
        prio(5'd15, 3'h3);
        slow <= 1'b1;
        auto <= 1'b1;
        irq_i <= 20'h2;
        @(posedge clk_i);
        irq_i <= 20'h0;
        w = 1'b0;
        for (k = 0; k < 12 && !w; k++)
        begin
            @(posedge clk_i);
            #1;
            w = take_i;
        end
        chk(w, 1, "taken");
        @(posedge clk_i);
        auto <= 1'b0;
        sleep(ewim_pkg::MODE_1);
        irq_i <= 20'h8000;
        wait_wake(w);
        chk(w, 0, "equal level wake");
        prio(5'd15, 3'h2);
        wait_wake(w);
        chk(w, 1, "higher level wake");
        @(posedge clk_i);
        #1;
        chk(irq_valid_o, 1, "served after wake");
        chk(irq_pos_o, 5'hf, "position after wake");
        @(posedge clk_i);
        exit_i <= 1'b1;
        @(posedge clk_i);
        exit_i <= 1'b0;
        $display("test handler done");
        report_and_stop;
    end
    initial
    begin
        repeat (5000) @(posedge clk_i);
        n_fail++;
        $display("BAD t=%0t watchdog", $time);
        report_and_stop;
    end
endmodule
